//--- rtl/fes_params.svh
`ifndef FES_PARAMS_SVH
`define FES_PARAMS_SVH
// Notes on behaviour
// RL1: Chip erase is six writes: two unlocks, set-up, two unlocks, chip-erase code.
// RL2: Device preprograms and verifies to zeros itself; host adds nothing.
// RL3: After chip erase the device returns to array read, no address latched.
// RL4: During chip erase progress shows on poll, toggle and suspend-toggle bits.
// RL5: Chip erase ignores all bus commands; only hardware reset aborts it.
// RL6: Sector erase is six writes, the last carrying sector address and erase code.
// RL7: A 50 us window follows; each extra sector write inside it restarts it.
// RL8: The window runs from the rising write-strobe edge of the final write.
// RL9: Other commands inside the window abandon the sequence to read mode.
// RL10: Erase-timer flag shows whether the acceptance window has expired.
// RL11: Once sector erase runs only suspend is taken; hardware reset aborts.
// RL12: No secure area, identification or query mode during any erase.
// RL13: Suspend code B0h works only in sector erase, including its window.
// RL14: Suspend during active erasing halts it within 20 us, typically 5.
// RL15: Suspend inside the window ends it and suspends at once.
// RL16: Suspended state serves other sectors; suspended sectors read status.
// RL17: Poll bit, or toggle plus suspend-toggle, tell erasing from suspended.
// RL18: Program during suspend reports as usual, then returns to suspended read.
// RL19: Identification entry is accepted in the suspended read state.
// RL20: Resume restarts erase; repeats ignored; new suspend allowed after resume.
// RL21: Each suspend redoes unfinished sub-steps, lengthening total erase time.
// RL22: After a hardware reset abort the host reissues the whole erase sequence.
// RL23: Target sector is decoded from the sector select bits alone.
// RL24: Unlock and command writes ignore high address bits and high data bits.
// RL25: Resume is honoured only in the erase-suspended state.
// RL26: Exceeded-limit flag seen in status makes the host write reset command.
// RL27: Busy indication holds from erase start until done, suspend or reset.

// Register byte offsets.
`define FES_OFF_CTRL 4'h0
`define FES_OFF_ADDR 4'h4
`define FES_OFF_STAT 4'h8
`define FES_OFF_DATA 4'hc

// Operation codes written to the control register.
`define FES_OP_CHIP 4'h1
`define FES_OP_SECT 4'h2
`define FES_OP_MORE 4'h3
`define FES_OP_SUSP 4'h4
`define FES_OP_RESUME 4'h5
`define FES_OP_SWRST 4'h6
`define FES_OP_POLL 4'h7
`define FES_OP_HWRST 4'h8

// Flash command words.
`define FES_UNLK_A1 22'h000555
`define FES_UNLK_A2 22'h0002aa
`define FES_UNLK_D1 16'h00aa
`define FES_UNLK_D2 16'h0055
`define FES_CMD_SETUP 16'h0080
`define FES_CMD_CHIP 16'h0010
`define FES_CMD_SECT 16'h0030
`define FES_CMD_SUSP 16'h00b0
`define FES_CMD_RESUME 16'h0030
`define FES_CMD_RESET 16'h00f0
`define FES_SECT_LSB 15
`define FES_SEQ_LAST 3'h5

// Status bit positions within the low status byte.
`define FES_BIT_POLL 7
`define FES_BIT_TOGGLE 6
`define FES_BIT_EXCEED 5
`define FES_BIT_TIMER 3
`define FES_BIT_STOG 2

// Timing: times as printed or chosen, cycles derived at 50 MHz.
`define FES_CLK_MHZ 50
`define FES_T_WIN_US 50
`define FES_WIN_CYC (`FES_T_WIN_US * `FES_CLK_MHZ)
`define FES_T_STROBE_NS 40
`define FES_STROBE_CYC ((`FES_T_STROBE_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_T_ACC_NS 100
`define FES_ACC_CYC ((`FES_T_ACC_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_T_RP_NS 500
`define FES_RP_CYC ((`FES_T_RP_NS * `FES_CLK_MHZ + 999) / 1000)
`endif

//--- rtl/fes_pkg.sv
package fes_pkg;
	typedef enum logic [1:0] {
		FES_S_IDLE = 2'b00,
		FES_S_ISSUE = 2'b01,
		FES_S_WAIT = 2'b10,
		FES_S_HWRST = 2'b11
	} fes_seq_t;

	typedef enum logic [2:0] {
		FES_C_IDLE = 3'b000,
		FES_C_STROBE = 3'b001,
		FES_C_SAMPLE = 3'b010,
		FES_C_GAP = 3'b011
	} fes_cyc_t;

	typedef struct packed {
		fes_seq_t st;
		logic [3:0] op;
		logic [2:0] idx;
		logic [21:0] sect_addr;
		logic [15:0] rdata;
		logic ack;
		logic [31:0] wb_dat;
		logic req;
		logic req_we;
		logic [21:0] req_addr;
		logic [15:0] req_data;
		logic [11:0] win_cnt;
		logic rb_s1;
		logic rb_s2;
		logic rb_s3;
		logic rb_q;
		logic rst_n;
		logic [7:0] rst_cnt;
		logic [2:0] wcnt;
	} fes_main_t;

	typedef struct packed {
		fes_cyc_t st;
		logic we;
		logic [7:0] cnt;
		logic [21:0] addr;
		logic [15:0] dq_o;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [15:0] d1;
		logic [15:0] d2;
		logic [15:0] d3;
		logic [15:0] rdata;
		logic done;
	} fes_cyc_state_t;
endpackage

//--- rtl/fes_cyc_if.sv
`timescale 1ns/1ps
// Request path from the sequencer to the bus cycle engine.
interface fes_cyc_if;
	logic req;
	logic we;
	logic [21:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport seq (output req, output we, output addr, output wdata, input done, input rdata);
	modport eng (input req, input we, input addr, input wdata, output done, output rdata);
endinterface

//--- rtl/fes_cycle.sv
`timescale 1ns/1ps
`include "fes_params.svh"
// One flash bus cycle per request: a write strobe or a read with synchronised sampling.
module fes_cycle (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Sequencer side.
	fes_cyc_if.eng cyc,
	// Flash pins.
	output logic [21:0] addr_o,
	output logic [15:0] dq_o,
	output logic dq_oe_o,
	input wire logic [15:0] dq_i,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o
);
	fes_pkg::fes_cyc_state_t q, d;

	// --------------------------------------------------------------
	// Next state.
	// --------------------------------------------------------------
	// The data pins pass three flops; a read is taken once stages two and three agree.
	always_comb begin
		d = q;
		d.d1 = dq_i;
		d.d2 = q.d1;
		d.d3 = q.d2;
		d.done = 1'b0;
		unique case (q.st)
			fes_pkg::FES_C_IDLE: begin
				if (cyc.req) begin
					d.we = cyc.we;
					d.addr = cyc.addr;
					d.dq_o = cyc.wdata;
					d.dq_oe = cyc.we;
					d.ce_n = 1'b0;
					d.we_n = ~cyc.we;
					d.oe_n = cyc.we;
					d.cnt = cyc.we ? 8'(`FES_STROBE_CYC) : 8'(`FES_ACC_CYC);
					d.st = fes_pkg::FES_C_STROBE;
				end
			end
			fes_pkg::FES_C_STROBE: begin
				if (q.cnt != 8'h00) begin
					d.cnt = q.cnt - 8'h01;
				end else if (q.we) begin
					d.we_n = 1'b1; // Rising strobe edge starts the device's window.
					d.st = fes_pkg::FES_C_GAP;
				end else begin
					d.st = fes_pkg::FES_C_SAMPLE;
				end
			end
			fes_pkg::FES_C_SAMPLE: begin
				if (q.d2 == q.d3) begin
					d.rdata = q.d3;
					d.oe_n = 1'b1;
					d.st = fes_pkg::FES_C_GAP;
				end
			end
			fes_pkg::FES_C_GAP: begin
				d.ce_n = 1'b1;
				d.dq_oe = 1'b0;
				d.done = 1'b1;
				d.st = fes_pkg::FES_C_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------
	// State register.
	// --------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.ce_n <= 1'b1;
			q.oe_n <= 1'b1;
			q.we_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs come straight from the state flops.
	assign addr_o = q.addr;
	assign dq_o = q.dq_o;
	assign dq_oe_o = q.dq_oe;
	assign ce_n_o = q.ce_n;
	assign oe_n_o = q.oe_n;
	assign we_n_o = q.we_n;
	assign cyc.done = q.done;
	assign cyc.rdata = q.rdata;
endmodule // fes_cycle

//--- rtl/fes_host.sv
`timescale 1ns/1ps
`include "fes_params.svh"
// Host controller issuing erase, suspend, resume, reset and poll sequences to the flash.
module fes_host #(
	parameter int WIN_CYC = `FES_WIN_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Flash pins.
	output logic [21:0] flash_addr_o,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [15:0] flash_dq_i,
	output logic flash_ce_n_o,
	output logic flash_oe_n_o,
	output logic flash_we_n_o,
	output logic flash_reset_n_o,
	input wire logic flash_ready_busy_n_i
);
	generate
		if (WIN_CYC < 1 || WIN_CYC > 4095) begin : g_bad_win
			$error("WIN_CYC must fit the 12-bit window counter");
		end
	endgenerate

	fes_pkg::fes_main_t q, d;
	fes_cyc_if cyc ();
	logic [21:0] step_addr;
	logic [15:0] step_data;
	logic step_last;
	logic acc;

	// --------------------------------------------------------------
	// Sequence table.
	// --------------------------------------------------------------
	// Unlock words use only low address and data bits; the sector word carries the
	// sector select bits with the rest zeroed. [RL24] [RL23]
	always_comb begin
		step_addr = `FES_UNLK_A1;
		step_data = `FES_CMD_RESET;
		step_last = 1'b1;
		unique case (q.op)
			`FES_OP_CHIP, `FES_OP_SECT: begin
				step_last = (q.idx == `FES_SEQ_LAST);
				unique case (q.idx)
					3'h0, 3'h3: step_data = `FES_UNLK_D1;
					3'h1, 3'h4: begin
						step_addr = `FES_UNLK_A2;
						step_data = `FES_UNLK_D2;
					end
					3'h2: step_data = `FES_CMD_SETUP;
					default: begin
						if (q.op == `FES_OP_CHIP) begin
							step_data = `FES_CMD_CHIP; // [RL1]
						end else begin
							step_addr = {q.sect_addr[21:`FES_SECT_LSB], 15'h0000}; // [RL6]
							step_data = `FES_CMD_SECT;
						end
					end
				endcase
			end
			`FES_OP_MORE, `FES_OP_POLL: begin
				step_addr = {q.sect_addr[21:`FES_SECT_LSB], 15'h0000};
				step_data = `FES_CMD_SECT;
			end
			`FES_OP_SUSP: step_data = `FES_CMD_SUSP;
			`FES_OP_RESUME: step_data = `FES_CMD_RESUME;
			default: step_data = `FES_CMD_RESET;
		endcase
	end

	// --------------------------------------------------------------
	// Next state.
	// --------------------------------------------------------------
	// A new order is taken only when idle; orders written while busy are dropped.
	always_comb begin
		d = q;
		d.req = 1'b0;
		acc = wb_cyc_i && wb_stb_i && !q.ack;
		d.ack = acc;
		// Ready/busy pin: three flops, a change counts when stages two and three agree.
		d.rb_s1 = flash_ready_busy_n_i;
		d.rb_s2 = q.rb_s1;
		d.rb_s3 = q.rb_s2;
		if (q.rb_s2 == q.rb_s3) begin
			d.rb_q = q.rb_s3;
		end
		if (q.win_cnt != 12'h000) begin
			d.win_cnt = q.win_cnt - 12'h001;
		end
		unique case (wb_adr_i)
			`FES_OFF_CTRL: d.wb_dat = {28'h0000000, q.op};
			`FES_OFF_ADDR: d.wb_dat = {10'h000, q.sect_addr};
			`FES_OFF_STAT: d.wb_dat = {16'h0000, q.rdata[7:0], 4'h0, q.rb_q,
				(q.win_cnt != 12'h000), 1'b0, (q.st != fes_pkg::FES_S_IDLE)};
			`FES_OFF_DATA: d.wb_dat = {16'h0000, q.rdata};
			default: d.wb_dat = 32'h00000000;
		endcase
		if (acc && wb_we_i && wb_adr_i == `FES_OFF_ADDR) begin
			// Lanes 0 and 1 are full bytes; lane 2 carries only the top six address bits.
			for (int b = 0; b < 2; b++) begin
				if (wb_sel_i[b]) begin
					d.sect_addr[b*8 +: 8] = wb_dat_i[b*8 +: 8];
				end
			end
			if (wb_sel_i[2]) begin
				d.sect_addr[21:16] = wb_dat_i[21:16];
			end
		end
		unique case (q.st)
			fes_pkg::FES_S_IDLE: begin
				if (acc && wb_we_i && wb_adr_i == `FES_OFF_CTRL && wb_sel_i[0]) begin
					d.op = wb_dat_i[3:0];
					d.idx = 3'h0;
					d.wcnt = 3'h0;
					if (wb_dat_i[3:0] == `FES_OP_HWRST) begin
						d.rst_n = 1'b0;
						d.rst_cnt = 8'(`FES_RP_CYC);
						d.st = fes_pkg::FES_S_HWRST;
					end else if (wb_dat_i[3:0] != 4'h0 && wb_dat_i[3:0] < `FES_OP_HWRST) begin
						d.st = fes_pkg::FES_S_ISSUE;
					end
				end
			end
			fes_pkg::FES_S_ISSUE: begin
				d.req = 1'b1;
				d.req_we = (q.op != `FES_OP_POLL);
				d.req_addr = step_addr;
				d.req_data = step_data;
				d.st = fes_pkg::FES_S_WAIT;
			end
			fes_pkg::FES_S_WAIT: begin
				if (cyc.done) begin
					if (q.req_we) begin
						d.wcnt = q.wcnt + 3'h1;
					end else begin
						d.rdata = cyc.rdata;
					end
					if (!step_last) begin
						d.idx = q.idx + 3'h1;
						d.st = fes_pkg::FES_S_ISSUE;
					end else if (q.op == `FES_OP_POLL && cyc.rdata[`FES_BIT_EXCEED]) begin
						d.op = `FES_OP_SWRST; // [RL26]
						d.idx = 3'h0;
						d.st = fes_pkg::FES_S_ISSUE;
					end else begin
						d.st = fes_pkg::FES_S_IDLE;
						// The host's own view of the device window, loaded when the final write reports done, two cycles after the strobe's rise. [RL7]
						if (q.op == `FES_OP_SECT || q.op == `FES_OP_MORE) begin
							d.win_cnt = 12'(WIN_CYC);
						end else if (q.op != `FES_OP_POLL) begin
							d.win_cnt = 12'h000;
						end
					end
				end
			end
			fes_pkg::FES_S_HWRST: begin
				// Reset pin low for the whole count; software must then reissue the
				// erase sequence, since the abort loses it. [RL22]
				d.win_cnt = 12'h000;
				if (q.rst_cnt != 8'h00) begin
					d.rst_cnt = q.rst_cnt - 8'h01;
				end else begin
					d.rst_n = 1'b1;
					d.st = fes_pkg::FES_S_IDLE;
				end
			end
		endcase
	end

	// --------------------------------------------------------------
	// State register.
	// --------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.rst_n <= 1'b1;
			q.rb_s1 <= 1'b1;
			q.rb_s2 <= 1'b1;
			q.rb_s3 <= 1'b1;
			q.rb_q <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign cyc.req = q.req;
	assign cyc.we = q.req_we;
	assign cyc.addr = q.req_addr;
	assign cyc.wdata = q.req_data;
	assign wb_dat_o = q.wb_dat;
	assign wb_ack_o = q.ack;
	assign flash_reset_n_o = q.rst_n;

	// Bus cycle engine.
	fes_cycle u_cycle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc(cyc),
		.addr_o(flash_addr_o),
		.dq_o(flash_dq_o),
		.dq_oe_o(flash_dq_oe_o),
		.dq_i(flash_dq_i),
		.ce_n_o(flash_ce_n_o),
		.oe_n_o(flash_oe_n_o),
		.we_n_o(flash_we_n_o)
	);

	// --------------------------------------------------------------
	// Assertions.
	// --------------------------------------------------------------
	a_chip_six_writes: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
		(q.st == fes_pkg::FES_S_WAIT && cyc.done && q.op == `FES_OP_CHIP && step_last)
		|=> q.wcnt == 3'h6)
		else $error("chip erase did not issue six writes");
	a_sect_six_writes: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
		(q.st == fes_pkg::FES_S_WAIT && cyc.done && q.op == `FES_OP_SECT && step_last)
		|=> q.wcnt == 3'h6 && q.req_addr[14:0] == 15'h0000 && q.req_data == `FES_CMD_SECT)
		else $error("sector erase sequence malformed");
	a_window_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
		(q.st == fes_pkg::FES_S_WAIT && cyc.done && step_last &&
		(q.op == `FES_OP_SECT || q.op == `FES_OP_MORE)) |=> q.win_cnt == 12'(WIN_CYC) ##1
		q.win_cnt == 12'(WIN_CYC - 1))
		else $error("acceptance window not restarted");
	a_hwrst_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RL22]
		$fell(flash_reset_n_o) |-> !flash_reset_n_o [*8] ##[1:300] flash_reset_n_o)
		else $error("hardware reset pulse length wrong");
	a_exceed_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [RL26]
		(q.st == fes_pkg::FES_S_WAIT && cyc.done && q.op == `FES_OP_POLL &&
		cyc.rdata[`FES_BIT_EXCEED]) |=> ##[1:40] (flash_we_n_o == 1'b0 &&
		flash_dq_o == `FES_CMD_RESET))
		else $error("exceeded flag not followed by reset command");
	c_chip: cover property (@(posedge clk_i) q.op == `FES_OP_CHIP && q.st == fes_pkg::FES_S_IDLE
		&& q.wcnt == 3'h6);
	c_sect_more: cover property (@(posedge clk_i) q.op == `FES_OP_MORE && q.win_cnt != 12'h000);
	c_suspend: cover property (@(posedge clk_i) q.op == `FES_OP_SUSP && cyc.done);
endmodule // fes_host

//--- sim/fes_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash device answering the erase commands of the controller.
module fes_flash_model #(
	parameter int WIN_CYC = 200,
	parameter int ERASE_CYC = 400
) (
	// Clock that paces the internal algorithm and samples the bus strobes.
	input wire logic clk_i,
	// Flash pins.
	input wire logic [21:0] addr_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic reset_n_i,
	// Test knob that makes a running sector erase report a timing failure.
	input wire logic fail_i,
	output logic ready_busy_n_o
);
	// ----------------------------------------
	// Device state
	// ----------------------------------------
	localparam logic [2:0] M_READ = 3'h0;
	localparam logic [2:0] M_WIN = 3'h1;
	localparam logic [2:0] M_ERASE = 3'h2;
	localparam logic [2:0] M_SUSP = 3'h3;
	localparam logic [2:0] M_CHIP = 3'h4;
	logic [2:0] mode = 3'h0;
	logic [2:0] step = 3'h0;
	logic [6:0] sect_q = 7'h00;
	int nsect = 0;
	int win_cnt = 0;
	int ers_cnt = 0;
	logic we_n_q = 1'b1;
	logic oe_n_q = 1'b1;
	logic tog_q = 1'b0;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] stat;
	logic [10:0] a;
	logic [7:0] d;

	// Expected address and data of each unlock and set-up step.
	function automatic logic unlock_ok(input logic [2:0] s, input logic [10:0] fa,
		input logic [7:0] fd);
		case (s)
			3'h0, 3'h3: return fa == 11'h555 && fd == 8'haa;
			3'h1, 3'h4: return fa == 11'h2aa && fd == 8'h55;
			3'h2: return fa == 11'h555 && fd == 8'h80;
			default: return 1'b0;
		endcase
	endfunction

	// Commands are taken at the rising write strobe; the window runs from that edge.
	always @(posedge clk_i) begin
		we_n_q <= we_n_i;
		oe_n_q <= oe_n_i;
		if (!reset_n_i) begin
			mode <= M_READ;
			step <= 3'h0;
			nsect <= 0;
		end else begin
			if (oe_n_q && !oe_n_i && !ce_n_i && mode != M_READ)
				tog_q <= ~tog_q;
			if (mode == M_WIN) begin
				win_cnt <= win_cnt + 1;
				if (win_cnt >= WIN_CYC)
					mode <= M_ERASE;
			end
			if (mode == M_ERASE || mode == M_CHIP) begin
				ers_cnt <= ers_cnt + 1; // Preprogram, verify and erase need no host help
				if (ers_cnt >= ERASE_CYC)
					mode <= M_READ;
			end
			if (!we_n_q && we_n_i && !ce_n_i) begin
				a = addr_i[10:0];
				d = dq_i[7:0];
				case (mode)
					M_READ: begin
						step <= 3'h0;
						if (step == 3'h5 && a == 11'h555 && d == 8'h10) begin
							mode <= M_CHIP;
							ers_cnt <= 0;
						end else if (step == 3'h5 && d == 8'h30) begin
							mode <= M_WIN;
							win_cnt <= 0;
							ers_cnt <= 0;
							sect_q <= addr_i[21:15];
							nsect <= 1;
						end else if (unlock_ok(step, a, d))
							step <= step + 3'h1;
					end
					M_WIN: begin
						if (d == 8'h30) begin
							win_cnt <= 0;
							sect_q <= addr_i[21:15];
							nsect <= nsect + 1;
						end else if (d == 8'hb0)
							mode <= M_SUSP;
						else
							mode <= M_READ;
					end
					M_ERASE: begin
						if (d == 8'hb0) begin
							mode <= M_SUSP; // Halts at once, well inside the limit
							ers_cnt <= ers_cnt - ers_cnt % 16;
						end else if (d == 8'hf0 && fail_i) begin
							mode <= M_READ; // The reset command leaves the erase only while fail_i reports a failure.
						end
					end
					M_SUSP: begin
						if (d == 8'h30)
							mode <= M_ERASE;
						else
							mode <= M_SUSP; // Program and id entry keep suspended read
					end
					default: ; // Chip erase ignores all, id and query too
				endcase
			end
		end
		if (!ce_n_i && !oe_n_i)
			last_q <= dq_o;
	end

	// Status while busy; a released bus shows the inverse of the last word.
	always_comb begin
		stat = {8'h00, mode == M_SUSP, (mode != M_SUSP) & tog_q, fail_i && mode == M_ERASE,
			1'b0, mode != M_WIN, tog_q, 2'b00};
		if (!ce_n_i && !oe_n_i)
			dq_o = (mode == M_READ) ? 16'hffff : stat;
		else
			dq_o = ~last_q;
		ready_busy_n_o = !(mode == M_WIN || mode == M_ERASE || mode == M_CHIP);
	end
endmodule // fes_flash_model

//--- sim/flash_erase_sequencer_bench.sv
`timescale 1ns/1ps
// Self-checking bench of the erase controller against the device model.
module flash_erase_sequencer_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int WIN = 200;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [21:0] f_addr;
	logic [15:0] f_dq_w;
	logic [15:0] f_dq_r;
	logic f_ce_n, f_oe_n, f_we_n, f_rst_n, f_rb_n;
	logic f_dq_oe;
	logic f_fail = 1'b0;
	int mismatches = 0;
	int samples_checked = 0;
	integer seed = 32'h48d9;
	logic [31:0] q;
	logic [31:0] r;

	always #10 clk_i = ~clk_i;

	fes_host #(.WIN_CYC(WIN)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_addr_o(f_addr),
		.flash_dq_o(f_dq_w), .flash_dq_oe_o(f_dq_oe), .flash_dq_i(f_dq_r), .flash_ce_n_o(f_ce_n),
		.flash_oe_n_o(f_oe_n), .flash_we_n_o(f_we_n), .flash_reset_n_o(f_rst_n),
		.flash_ready_busy_n_i(f_rb_n));
	fes_flash_model #(.WIN_CYC(WIN)) i_flash (.clk_i(clk_i), .addr_i(f_addr), .dq_i(f_dq_w),
		.dq_o(f_dq_r), .ce_n_i(f_ce_n), .oe_n_i(f_oe_n), .we_n_i(f_we_n), .reset_n_i(f_rst_n),
		.fail_i(f_fail), .ready_busy_n_o(f_rb_n));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic fail(input string msg);
		$display("wrong value at %0t ns: %s", $time, msg);
		mismatches++;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
			fail($sformatf("%s got %h want %h", m, got, exp));
	endtask

	task automatic check_mode(input logic [2:0] exp);
		samples_checked++;
		if (i_flash.mode !== exp)
			fail($sformatf("device mode %h want %h", i_flash.mode, exp));
	endtask

	// Classic cycle: held until ack is sampled high, then released for a cycle.
	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
		input logic [31:0] dat, output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50) begin
			fail("bus answer missing");
			summarize();
		end else begin
			@(posedge clk_i);
		end
	endtask

	// Polls the status register until one bit reaches a level.
	task automatic wait_stat(input int b, input logic v);
		int n;
		n = 0;
		do begin
			wb(1'b0, 4'h8, 4'hf, 32'h0, q);
			n++;
		end while (q[b] !== v && n < 600);
		if (n >= 600) begin
			fail("status bit stuck");
			summarize();
		end
	endtask

	task automatic op(input logic [3:0] code);
		wb(1'b1, 4'h0, 4'h1, {28'h0, code}, q);
		wait_stat(0, 1'b0);
	endtask

	// Sets a random sector address and returns its select bits.
	task automatic pick(output logic [6:0] s);
		r = $random(seed);
		wb(1'b1, 4'h4, 4'h7, r, q);
		s = r[21:15];
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [6:0] s;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 4'h0, 4'hf, 32'h0, q);
		check_word(q, 32'h0, "control after reset");
		wb(1'b0, 4'h2, 4'hf, 32'h0, q);
		check_word(q, 32'h0, "unmapped read");
		check_word({31'h0, f_dq_oe}, 32'h0, "data pins released");
		wb(1'b1, 4'h0, 4'h1, 32'hf, q);
		wb(1'b0, 4'h8, 4'hf, 32'h0, q);
		check_word(q & 32'h1, 32'h0, "unused code left idle");
		$display("test registers done");

		op(4'h1);
		check_mode(3'h4);
		wait_stat(3, 1'b0);
		op(4'h7);
		wb(1'b0, 4'hc, 4'hf, 32'h0, q);
		check_word({31'h0, q[7]}, 32'h0, "poll bit in chip erase");
		op(4'h4);
		check_mode(3'h4);
		wait_stat(3, 1'b1);
		check_mode(3'h0);
		$display("test chip erase done");

		repeat (3) begin
			pick(s);
			op(4'h2);
			check_mode(3'h1);
			check_word({25'h0, i_flash.sect_q}, {25'h0, s}, "latched sector");
			op(4'h6);
			check_mode(3'h0);
		end
		$display("test window abort done");

		pick(s);
		op(4'h2);
		pick(s);
		op(4'h3);
		check_word(i_flash.nsect, 32'h2, "queued sectors");
		check_word({31'h0, q[2]}, 32'h1, "host window open");
		op(4'h7);
		wb(1'b0, 4'hc, 4'hf, 32'h0, q);
		check_word({31'h0, q[3]}, 32'h0, "timer flag in window");
		op(4'h4);
		check_mode(3'h3);
		op(4'h7);
		wb(1'b0, 4'hc, 4'hf, 32'h0, q);
		check_word({31'h0, q[7]}, 32'h1, "poll bit suspended");
		op(4'h5);
		check_mode(3'h2);
		op(4'h5);
		check_mode(3'h2);
		op(4'h7);
		wb(1'b0, 4'hc, 4'hf, 32'h0, q);
		check_word({30'h0, q[7], q[3]}, 32'h1, "erasing status");
		op(4'h4);
		check_mode(3'h3);
		op(4'h5);
		op(4'h8);
		check_mode(3'h0);
		wait_stat(3, 1'b1);
		$display("test sector erase done");

		// After the abort the whole sequence is issued again and left to run into erasure.
		pick(s);
		op(4'h2);
		repeat (WIN + 20) @(posedge clk_i);
		check_mode(3'h2);
		f_fail <= 1'b1;
		op(4'h7);
		f_fail <= 1'b0;
		wb(1'b0, 4'hc, 4'hf, 32'h0, q);
		check_word({31'h0, q[5]}, 32'h1, "exceeded flag seen");
		check_mode(3'h0);
		$display("test failed erase done");
		summarize();
	end
endmodule // flash_erase_sequencer_bench
